//--- logic/pattern_port.sv
`include "pattern_port_cfg.svh"

module pattern_port
    import pattern_port_pkg::*;
#(
    parameter int GROUPS = 4,
    parameter int AUX_LINES = 8
) (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic [31:0] pad_data_i,
    output logic [31:0] pad_data_o,
    output logic [31:0] pad_data_oe_o,
    input wire logic sample_valid_i,
    input wire logic [31:0] tx_data_i,
    input wire logic tx_valid_i,
    input wire logic di_dma_active_i,
    input wire logic do_dma_active_i,
    output logic [31:0] word_o,
    output logic word_valid_o,
    output logic led_red_o,
    output logic led_green_o,
    output logic [1:0] level_sel_o,
    output logic [31:0] aux_function_line_o
);

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Bytes carried by one sample of the given width
    function automatic logic [2:0] width_bytes(input logic [1:0] w);
        width_bytes = {1'b0, w} + 3'h1;
    endfunction

    // Groups a width reads: port A always, then B, C, D upward
    function automatic logic [3:0] width_groups(input logic [1:0] w);
        width_groups = 4'hF >> (2'h3 - w);
    endfunction

    // ****************************************************************
    // Bus and register state
    // ****************************************************************
    logic wr_pend_ff, nxt_wr_pend; // Write waiting for its data phase
    logic [7:0] wr_addr_ff, nxt_wr_addr; // Latched write offset
    logic [31:0] hrdata_ff, nxt_hrdata; // Read data for data phase
    logic [3:0] dir_ff, nxt_dir; // Group direction, 1 = output
    logic [1:0] level_ff, nxt_level; // Logic level choice
    logic [1:0] width_ff, nxt_width; // Sample width code
    logic rej_ff, nxt_rej; // Sticky width-rejected flag
    logic [31:0] aux_ff, nxt_aux; // Aux line roles, 4 bits each
    logic width_wr; // Accepted width change, flushes packer
    logic red_ff, nxt_red; // Indicator red element
    logic green_ff, nxt_green; // Indicator green element
    logic [3:0] drv_ff; // Groups actually driving
    logic [1:0] fill_ff; // Bytes held in packer

    logic addr_ok; // Valid address phase this cycle
    logic [3:0] w_dir; // Direction field of write data
    logic [1:0] w_width; // Width field of write data
    aux_role_t role; // Role under check in aux write loop

    // Next values for bus slave and registers
    always_comb begin
        role = AUX_NONE;
        nxt_wr_pend = wr_pend_ff;
        nxt_wr_addr = wr_addr_ff;
        nxt_hrdata = hrdata_ff;
        nxt_dir = dir_ff;
        nxt_level = level_ff;
        nxt_width = width_ff;
        nxt_rej = rej_ff;
        nxt_aux = aux_ff;
        width_wr = 1'b0;
        w_dir = hwdata_i[`PP_DIR_LSB +: 4];
        w_width = hwdata_i[`PP_WIDTH_LSB +: 2];
        addr_ok = hsel_i && hready_i && (htrans_i == `PP_HTRANS_NONSEQ
                  || htrans_i == `PP_HTRANS_SEQ);
        // Data phase of a pending write
        if (wr_pend_ff) begin
            nxt_wr_pend = 1'b0;
            if (wr_addr_ff == `PP_CTRL_OFS) begin
                nxt_dir = w_dir;
                nxt_level = hwdata_i[`PP_LEVEL_LSB +: 2];
                // Width must not reach a group set for output
                if ((width_groups(w_width) & w_dir) != 4'h0) begin
                    nxt_rej = 1'b1;
                end else begin
                    nxt_width = w_width;
                    nxt_rej = 1'b0;
                    width_wr = (w_width != width_ff);
                end
            end else if (wr_addr_ff == `PP_AUX_OFS) begin
                for (int i = 0; i < AUX_LINES; i++) begin
                    role = aux_role_t'(hwdata_i[4*i +: 4]);
                    nxt_aux[4*i +: 4] = role;
                    // Clock roles exist only on their dedicated lines
                    if ((role == AUX_CLK_IN || role == AUX_CLK_OUT) &&
                        i != `PP_AUX_DI_CLK_LINE &&
                        i != `PP_AUX_DO_CLK_LINE) begin
                        nxt_aux[4*i +: 4] = AUX_NONE;
                    end
                end
            end
        end
        // Address phase: capture write, prepare read word
        if (addr_ok) begin
            nxt_wr_pend = hwrite_i;
            nxt_wr_addr = haddr_i[7:0];
            nxt_hrdata = 32'h0000_0000;
            if (!hwrite_i) begin
                if (haddr_i[7:0] == `PP_CTRL_OFS) begin
                    nxt_hrdata[`PP_DIR_LSB +: 4] = nxt_dir;
                    nxt_hrdata[`PP_LEVEL_LSB +: 2] = nxt_level;
                    nxt_hrdata[`PP_WIDTH_LSB +: 2] = nxt_width;
                end else if (haddr_i[7:0] == `PP_STATUS_OFS) begin
                    nxt_hrdata[`PP_ST_DRV_LSB +: 4] = drv_ff;
                    nxt_hrdata[`PP_ST_REJ_BIT] = nxt_rej;
                    nxt_hrdata[`PP_ST_FILL_LSB +: 2] = fill_ff;
                    nxt_hrdata[`PP_ST_DI_BIT] = di_dma_active_i;
                    nxt_hrdata[`PP_ST_DO_BIT] = do_dma_active_i;
                end else if (haddr_i[7:0] == `PP_AUX_OFS) begin
                    nxt_hrdata = nxt_aux;
                end else begin
                    nxt_hrdata = 32'h0000_0000; // Unmapped reads zero
                end
            end
        end
        // Amber shows as both elements lit together
        nxt_red = di_dma_active_i;
        nxt_green = do_dma_active_i;
    end

    // Register bus and configuration state
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 8'h00;
            hrdata_ff <= 32'h0000_0000;
            dir_ff <= 4'(`PP_CTRL_RST);
            level_ff <= 2'h0;
            width_ff <= 2'h0;
            rej_ff <= 1'b0;
            aux_ff <= `PP_AUX_RST;
            red_ff <= 1'b0;
            green_ff <= 1'b0;
        end else if (ce_i) begin
            wr_pend_ff <= nxt_wr_pend;
            wr_addr_ff <= nxt_wr_addr;
            hrdata_ff <= nxt_hrdata;
            dir_ff <= nxt_dir;
            level_ff <= nxt_level;
            width_ff <= nxt_width;
            rej_ff <= nxt_rej;
            aux_ff <= nxt_aux;
            red_ff <= nxt_red;
            green_ff <= nxt_green;
        end
    end

    // ****************************************************************
    // Input synchroniser and sample packer
    // ****************************************************************
    logic [31:0] pin_s1_ff, pin_s2_ff; // Two-stage pin synchroniser
    logic [1:0] vld_dly_ff; // Strobe delayed to match data
    logic [23:0] acc_ff, nxt_acc; // Leftover bytes of partial word
    logic [1:0] nxt_fill;
    logic [31:0] word_ff, nxt_word;
    logic word_valid_ff, nxt_word_valid;
    logic [55:0] merged; // Held bytes plus new sample
    logic [31:0] sample; // Masked sample, port A in low byte
    logic [2:0] total; // Bytes after merge

    // Packing next state
    always_comb begin
        nxt_acc = acc_ff;
        nxt_fill = fill_ff;
        nxt_word = word_ff;
        nxt_word_valid = 1'b0;
        // Unused upper groups are masked off the sample
        sample = pin_s2_ff & {{8{width_ff == WIDTH_32}},
                 {8{width_ff >= WIDTH_24}}, {8{width_ff >= WIDTH_16}},
                 8'hFF};
        merged = ({24'h00_0000, sample} << {fill_ff, 3'b000})
                 | {32'h0000_0000, acc_ff};
        total = {1'b0, fill_ff} + width_bytes(width_ff);
        if (width_wr) begin
            nxt_fill = 2'h0; // Drop partial word on width change
            nxt_acc = 24'h00_0000;
        end else if (vld_dly_ff[1]) begin
            if (total >= 3'h4) begin
                nxt_word = merged[31:0];
                nxt_word_valid = 1'b1;
                nxt_acc = merged[55:32];
                nxt_fill = 2'(total - 3'h4);
            end else begin
                nxt_acc = merged[23:0];
                nxt_fill = total[1:0];
            end
        end
    end

    // Packing registers
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_s1_ff <= 32'h0000_0000;
            pin_s2_ff <= 32'h0000_0000;
            vld_dly_ff <= 2'h0;
            acc_ff <= 24'h00_0000;
            fill_ff <= 2'h0;
            word_ff <= 32'h0000_0000;
            word_valid_ff <= 1'b0;
        end else if (ce_i) begin
            pin_s1_ff <= pad_data_i;
            pin_s2_ff <= pin_s1_ff;
            vld_dly_ff <= {vld_dly_ff[0], sample_valid_i};
            acc_ff <= nxt_acc;
            fill_ff <= nxt_fill;
            word_ff <= nxt_word;
            word_valid_ff <= nxt_word_valid;
        end
    end

    // ****************************************************************
    // Output drive
    // ****************************************************************
    logic [3:0] nxt_drv;
    logic [31:0] out_ff, nxt_out; // Pattern data on the pins
    logic [31:0] oe_ff, nxt_oe;

    // A group drives only once output data has arrived for it
    always_comb begin
        nxt_out = tx_valid_i ? tx_data_i : out_ff;
        for (int g = 0; g < GROUPS; g++) begin
            nxt_drv[g] = dir_ff[g] && (drv_ff[g] || tx_valid_i);
            nxt_oe[8*g +: 8] = {8{nxt_drv[g]}};
        end
    end

    // Output registers
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            drv_ff <= 4'h0;
            out_ff <= 32'h0000_0000;
            oe_ff <= 32'h0000_0000;
        end else if (ce_i) begin
            drv_ff <= nxt_drv;
            out_ff <= nxt_out;
            oe_ff <= nxt_oe;
        end
    end

    // ****************************************************************
    // Port hookup
    // ****************************************************************
    assign hrdata_o = hrdata_ff;
    assign hreadyout_o = rstn_i | 1'b1;
    assign hresp_o = 1'b0;
    assign pad_data_o = out_ff;
    assign pad_data_oe_o = oe_ff;
    assign word_o = word_ff;
    assign word_valid_o = word_valid_ff;
    assign led_red_o = red_ff;
    assign led_green_o = green_ff;
    assign level_sel_o = level_ff;
    assign aux_function_line_o = aux_ff;

endmodule

//--- logic/pattern_port_cfg.svh
`ifndef PATTERN_PORT_CFG_SVH
`define PATTERN_PORT_CFG_SVH

// ****************************************************************
// Register byte offsets (low address bits)
// ****************************************************************
`define PP_CTRL_OFS 8'h00
`define PP_STATUS_OFS 8'h04
`define PP_AUX_OFS 8'h08

// ****************************************************************
// Control register fields
// ****************************************************************
`define PP_DIR_LSB 0
`define PP_LEVEL_LSB 4
`define PP_WIDTH_LSB 6
`define PP_CTRL_RST 32'h0000_0000

// ****************************************************************
// Status register fields
// ****************************************************************
`define PP_ST_DRV_LSB 0
`define PP_ST_REJ_BIT 4
`define PP_ST_FILL_LSB 5
`define PP_ST_DI_BIT 7
`define PP_ST_DO_BIT 8

// ****************************************************************
// Aux function register
// ****************************************************************
`define PP_AUX_RST 32'h0000_0000
`define PP_AUX_DI_CLK_LINE 7
`define PP_AUX_DO_CLK_LINE 6

// ****************************************************************
// Bus transfer codes
// ****************************************************************
`define PP_HTRANS_NONSEQ 2'h2
`define PP_HTRANS_SEQ 2'h3

`endif

//--- logic/pattern_port_pkg.sv
package pattern_port_pkg;

    // Sample width selection codes
    typedef enum logic [1:0] {
        WIDTH_8 = 2'b00,
        WIDTH_16 = 2'b01,
        WIDTH_24 = 2'b10,
        WIDTH_32 = 2'b11
    } width_sel_t;

    // Logic level selection codes
    typedef enum logic [1:0] {
        LEVEL_1V8 = 2'b00,
        LEVEL_2V5 = 2'b01,
        LEVEL_3V3 = 2'b10
    } level_sel_t;

    // Aux line role codes
    typedef enum logic [3:0] {
        AUX_NONE = 4'b0000,
        AUX_I2C = 4'b0001,
        AUX_SPI = 4'b0010,
        AUX_HANDSHAKE = 4'b0011,
        AUX_TRIG_IN = 4'b0100,
        AUX_EVENT_OUT = 4'b0101,
        AUX_CLK_IN = 4'b0110,
        AUX_CLK_OUT = 4'b0111
    } aux_role_t;

endpackage

//--- verif/pattern_dev_model.sv
// *****
// Far-side device on the pattern lines
// *****
module pattern_dev_model (
    input wire logic [31:0] pad_data_o,
    input wire logic [31:0] pad_data_oe_o,
    input wire logic [31:0] pattern_i,
    input wire logic [31:0] drive_i,
    output logic [31:0] pad_data_i
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] far_bits; // Level the far side puts on each line
    // Released lines show the inverse, never a stale copy
    assign far_bits = (drive_i & pattern_i) | (~drive_i & ~pattern_i);
    // Wire level: the port wins where it drives
    assign pad_data_i = (pad_data_oe_o & pad_data_o) |
        (~pad_data_oe_o & far_bits);
endmodule

//--- verif/pattern_port_checker.sv
module pattern_port_checker (
    input wire logic clk_sys_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic sample_valid_i,
    input wire logic [31:0] tx_data_i,
    input wire logic tx_valid_i,
    input wire logic di_dma_active_i,
    input wire logic do_dma_active_i,
    input wire logic [31:0] pad_data_o,
    input wire logic [31:0] pad_data_oe_o,
    input wire logic word_valid_o,
    input wire logic led_red_o,
    input wire logic led_green_o,
    input wire logic [31:0] aux_function_line_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic aux_bad; // Clock role seen on a plain aux line
    logic rst_held_ff; // Reset already seen at the previous edge
    // Only lines six and seven may carry a clock role
    always_comb begin
        aux_bad = 1'b0;
        for (int i = 0; i < 6; i++) begin
            if (aux_function_line_o[4*i+1 +: 3] == 3'h3) begin
                aux_bad = 1'b1;
            end
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);
    // Skips the very first edge, before the reset has reached the lines
    always_ff @(posedge clk_sys_i) begin
        rst_held_ff <= !rstn_i;
    end
    sequence s_both;
        ce_i && di_dma_active_i && do_dma_active_i;
    endsequence
    sequence s_amber;
        led_red_o && led_green_o;
    endsequence
    a_led_red: assert property (ce_i && di_dma_active_i |=> led_red_o)
        else $error("red indicator missing");
    a_led_green: assert property (ce_i && do_dma_active_i |=>
        led_green_o)
        else $error("green indicator missing");
    a_led_amber: assert property (s_both |=> s_amber)
        else $error("amber indicator missing");
    a_led_dark: assert property (ce_i && !di_dma_active_i &&
        !do_dma_active_i |=> !led_red_o && !led_green_o)
        else $error("indicator lit while idle");
    a_oe_reset: assert property (disable iff (1'b0)
        !rstn_i && rst_held_ff |-> pad_data_oe_o == 32'h0000_0000)
        else $error("lines driven during reset");
    a_oe_groups: assert property (pad_data_oe_o == {
        {8{pad_data_oe_o[24]}}, {8{pad_data_oe_o[16]}},
        {8{pad_data_oe_o[8]}}, {8{pad_data_oe_o[0]}}})
        else $error("enable split inside a group");
    a_oe_cause: assert property ((pad_data_oe_o &
        ~$past(pad_data_oe_o)) != 32'h0000_0000 |-> $past(tx_valid_i))
        else $error("drive began without output data");
    a_pad_load: assert property (ce_i && tx_valid_i |=>
        pad_data_o == $past(tx_data_i))
        else $error("output data not loaded");
    a_word_cause: assert property (word_valid_o |->
        $past(sample_valid_i, 3))
        else $error("word without a completing sample");
    a_aux_clk: assert property (!aux_bad)
        else $error("clock role on a plain aux line");
endmodule
bind pattern_port pattern_port_checker chk_u (.clk_sys_i, .rstn_i, .ce_i,
    .sample_valid_i, .tx_data_i, .tx_valid_i, .di_dma_active_i,
    .do_dma_active_i, .pad_data_o, .pad_data_oe_o, .word_valid_o,
    .led_red_o, .led_green_o, .aux_function_line_o);

//--- verif/test_pattern_port.sv
`include "pattern_port_cfg.svh"
module test_pattern_port
    import pattern_port_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0, rstn_i = 1'b0, ce_i = 1'b1, hsel_i = 1'b0;
    logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, tx_data_i = 32'h0;
    logic [1:0] htrans_i = 2'h0;
    logic [2:0] hsize_i = 3'h2;
    logic hwrite_i = 1'b0, sample_valid_i = 1'b0, tx_valid_i = 1'b0;
    logic di_dma_active_i = 1'b0, do_dma_active_i = 1'b0;
    logic [31:0] pattern = 32'h0, drive = 32'hFFFF_FFFF;
    logic [31:0] hrdata_o, pad_data_i, pad_data_o, pad_data_oe_o, word_o;
    logic [31:0] aux_function_line_o, q;
    logic hreadyout_o, hresp_o, word_valid_o, led_red_o, led_green_o;
    logic [1:0] level_sel_o;
    wire logic hready_i = hreadyout_o; // Single slave owns the bus ready
    int num_errors = 0, samples_checked = 0;
    logic [31:0] words[$]; // Words seen at the transfer side
    always #2.5 clk_sys_i = ~clk_sys_i;
    pattern_port dut_u (.clk_sys_i, .rstn_i, .ce_i, .hsel_i, .haddr_i,
        .htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i, .hrdata_o,
        .hreadyout_o, .hresp_o, .pad_data_i, .pad_data_o, .pad_data_oe_o,
        .sample_valid_i, .tx_data_i, .tx_valid_i, .di_dma_active_i,
        .do_dma_active_i, .word_o, .word_valid_o, .led_red_o, .led_green_o,
        .level_sel_o, .aux_function_line_o);
    pattern_dev_model dev_u (.pad_data_o, .pad_data_oe_o,
        .pattern_i(pattern), .drive_i(drive), .pad_data_i);
    // Collect every packed word as it leaves
    always @(posedge clk_sys_i) begin
        if (word_valid_o === 1'b1) begin
            words.push_back(word_o);
        end
    end
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    // One single word transfer; waits on ready, never on a count
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk_sys_i);
        htrans_i <= `PP_HTRANS_NONSEQ;
        hsel_i <= 1'b1;
        haddr_i <= {24'h0, a};
        hwrite_i <= w;
        do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
        q = hrdata_o;
        @(posedge clk_sys_i);
    endtask
    // Present a pin value long enough to pass the synchroniser
    task automatic smp(input logic [31:0] v);
        pattern <= v;
        repeat (4) @(posedge clk_sys_i);
        sample_valid_i <= 1'b1;
        @(posedge clk_sys_i);
        sample_valid_i <= 1'b0;
    endtask
    task automatic t_reset();
        chk("oe", 32'h0, pad_data_oe_o);
        bus(1'b0, `PP_CTRL_OFS, 32'h0);
        chk("ctrl", `PP_CTRL_RST, q);
        bus(1'b0, `PP_AUX_OFS, 32'h0);
        chk("aux", `PP_AUX_RST, q);
        bus(1'b1, 8'h0C, 32'hFFFF_FFFF);
        bus(1'b0, 8'h0C, 32'h0);
        chk("unmapped", 32'h0, q);
        chk("hresp", 32'h0, {31'h0, hresp_o});
        bus(1'b0, `PP_CTRL_OFS, 32'h0);
        chk("ctrl kept", `PP_CTRL_RST, q);
        $display("t_reset done");
    endtask
    task automatic t_led();
        for (int k = 0; k < 4; k++) begin
            di_dma_active_i <= k[0];
            do_dma_active_i <= k[1];
            repeat (2) @(posedge clk_sys_i);
            chk("leds", 32'(k), {30'h0, led_green_o, led_red_o});
        end
        // Clock enable low must freeze the indicator where it stands
        ce_i <= 1'b0;
        di_dma_active_i <= 1'b0;
        do_dma_active_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        chk("leds frozen", 32'h3, {30'h0, led_green_o, led_red_o});
        ce_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        chk("leds off", 32'h0, {30'h0, led_green_o, led_red_o});
        $display("t_led done");
    endtask
    task automatic t_dir();
        drive <= 32'h0000_FFFF;
        bus(1'b1, `PP_CTRL_OFS, 32'h4C);
        chk("oe idle", 32'h0, pad_data_oe_o);
        tx_data_i <= 32'hA5C3_5A3C;
        tx_valid_i <= 1'b1;
        @(posedge clk_sys_i);
        tx_valid_i <= 1'b0;
        @(posedge clk_sys_i);
        chk("oe", 32'hFFFF_0000, pad_data_oe_o);
        chk("pins", 32'hA5C3_5A3C, pad_data_o);
        bus(1'b0, `PP_STATUS_OFS, 32'h0);
        chk("status", 32'h0000_000C, q & 32'h1F);
        bus(1'b1, `PP_CTRL_OFS, 32'h40);
        @(posedge clk_sys_i); // Drive drops one edge after the write
        chk("oe off", 32'h0, pad_data_oe_o);
        drive <= 32'hFFFF_FFFF;
        $display("t_dir done");
    endtask
    task automatic t_reject();
        bus(1'b1, `PP_CTRL_OFS, 32'hC8);
        bus(1'b0, `PP_STATUS_OFS, 32'h0);
        chk("rejected", 32'h10, q & 32'h10);
        bus(1'b0, `PP_CTRL_OFS, 32'h0);
        chk("width kept", 32'h48, q);
        bus(1'b1, `PP_CTRL_OFS, 32'h88);
        bus(1'b0, `PP_STATUS_OFS, 32'h0);
        chk("accepted", 32'h0, q & 32'h10);
        bus(1'b1, `PP_CTRL_OFS, 32'h0);
        $display("t_reject done");
    endtask
    task automatic t_pack(input width_sel_t w);
        int b;
        logic [7:0] bytes[$];
        logic [31:0] v;
        b = int'(w) + 1;
        bus(1'b1, `PP_CTRL_OFS, {24'h0, w, 6'h0});
        words.delete();
        for (int k = 0; k < 4; k++) begin
            v = 32'h8C4A_2613 + 32'h1111_1111 * k;
            smp(v);
            for (int j = 0; j < b; j++) bytes.push_back(v[8*j +: 8]);
        end
        repeat (6) @(posedge clk_sys_i);
        chk("word count", 32'(b), 32'(words.size()));
        for (int i = 0; i < b; i++) begin
            v = {bytes[4*i+3], bytes[4*i+2], bytes[4*i+1], bytes[4*i]};
            chk("word", v, words[i]);
        end
        $display("t_pack done");
    endtask
    task automatic t_level();
        for (int l = 0; l < 3; l++) begin
            bus(1'b1, `PP_CTRL_OFS, {26'h0, 2'(l), 4'h0});
            chk("level", 32'(l), {30'h0, level_sel_o});
            bus(1'b0, `PP_CTRL_OFS, 32'h0);
            chk("level rd", 32'(l) << 4, q);
        end
        $display("t_level done");
    endtask
    task automatic t_aux();
        bus(1'b1, `PP_AUX_OFS, 32'h6765_4321);
        chk("aux", 32'h6705_4321, aux_function_line_o);
        bus(1'b0, `PP_AUX_OFS, 32'h0);
        chk("aux rd", 32'h6705_4321, q);
        $display("t_aux done");
    endtask
    // Reset in mid-run while a group drives: lines must float again
    task automatic t_rearm();
        bus(1'b1, `PP_CTRL_OFS, 32'h48);
        tx_data_i <= 32'h3CA5_0F96;
        tx_valid_i <= 1'b1;
        @(posedge clk_sys_i);
        tx_valid_i <= 1'b0;
        @(posedge clk_sys_i);
        chk("oe before", 32'hFF00_0000, pad_data_oe_o);
        rstn_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        chk("oe in reset", 32'h0, pad_data_oe_o);
        rstn_i <= 1'b1;
        bus(1'b0, `PP_CTRL_OFS, 32'h0);
        chk("ctrl again", `PP_CTRL_RST, q);
        bus(1'b0, `PP_AUX_OFS, 32'h0);
        chk("aux again", `PP_AUX_RST, q);
        $display("t_rearm done");
    endtask
    task automatic close_out();
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Hang guard, far beyond the roughly 250 cycles the run needs
    initial begin
        #200000;
        num_errors++;
        close_out();
    end
    initial begin
        repeat (10) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        t_reset();
        t_led();
        t_dir();
        t_reject();
        t_pack(WIDTH_8);
        t_pack(WIDTH_16);
        t_pack(WIDTH_24);
        t_pack(WIDTH_32);
        t_level();
        t_aux();
        t_rearm();
        close_out();
    end
endmodule
